// File: tio_top.sv
// timer pin control: function code registers, bus slave, pin units
`timescale 1ns/10ps
`default_nettype none
module tio_top #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [tio_pkg::NUM_UNITS-1:0] cmp_match,
    input wire logic [tio_pkg::NUM_CH-1:0] cnt_clear,
    input wire logic cnt1_tick,
    input wire logic [tio_pkg::NUM_UNITS-1:0] pin_i,
    output logic [tio_pkg::NUM_UNITS-1:0] pin_o,
    output logic [tio_pkg::NUM_UNITS-1:0] pin_oe,
    output logic [tio_pkg::NUM_UNITS-1:0] capture
);
    localparam int N = tio_pkg::NUM_UNITS;

    logic [7:0] io_ctrl_ab_ch0_q, io_ctrl_cd_ch0_q, io_ctrl_ab_ch1_q, io_ctrl_ab_ch2_q;
    logic [tio_pkg::CTL_W-1:0] ctrl_q;
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q, rdata_d;
    logic wr_go, rd_go;
    logic [2:0] wr_idx, rd_idx;
    logic [N-1:0] sync1_q, sync2_q, sync3_q, lvl_q;
    logic seeded_q, buf_b_w, oc0_w;
    logic [1:0] warm_q;
    logic [N-1:0] agree_w, rise_w, fall_w;
    logic [4*N-1:0] codes_w;
    logic [2:0] start_w, pwm2_w, psc_w;

    // ======================================================
    // address decode, 3'h7 for unmapped
    function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
        logic [7:0] b;
        b = 8'(a);
        unique case (b)
            tio_pkg::OFF_IO_CTRL_AB_CH0: reg_index = 3'h0;
            tio_pkg::OFF_IO_CTRL_CD_CH0: reg_index = 3'h1;
            tio_pkg::OFF_IO_CTRL_AB_CH1: reg_index = 3'h2;
            tio_pkg::OFF_IO_CTRL_AB_CH2: reg_index = 3'h3;
            tio_pkg::OFF_TIMER_CTRL: reg_index = 3'h4;
            tio_pkg::OFF_PIN_STATUS: reg_index = 3'h5;
            default: reg_index = 3'h7;
        endcase
    endfunction : reg_index

    assign wr_idx = reg_index(s_axi_awaddr);
    assign rd_idx = reg_index(s_axi_araddr);
    assign wr_go = s_axi_awvalid & awready_q & s_axi_wvalid & wready_q;
    assign rd_go = s_axi_arvalid & arready_q;

    // ======================================================
    // write channel
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
        end
        else
        begin
            awready_q <= s_axi_awvalid & s_axi_wvalid & ~awready_q & ~bvalid_q;
            wready_q <= s_axi_awvalid & s_axi_wvalid & ~awready_q & ~bvalid_q;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= tio_pkg::RESP_OKAY;
        end
        else if (wr_go)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= (wr_idx == 3'h7) ? tio_pkg::RESP_SLVERR : tio_pkg::RESP_OKAY;
        end
        else if (s_axi_bready)
            bvalid_q <= 1'b0;
    end

    // function code registers
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            io_ctrl_ab_ch0_q <= tio_pkg::RST_IO_CTRL;
            io_ctrl_cd_ch0_q <= tio_pkg::RST_IO_CTRL;
            io_ctrl_ab_ch1_q <= tio_pkg::RST_IO_CTRL;
            io_ctrl_ab_ch2_q <= tio_pkg::RST_IO_CTRL;
        end
        else if (wr_go && s_axi_wstrb[0])
        begin
            if (wr_idx == 3'h0)
                io_ctrl_ab_ch0_q <= s_axi_wdata[7:0];
            if (wr_idx == 3'h1)
                io_ctrl_cd_ch0_q <= s_axi_wdata[7:0];
            if (wr_idx == 3'h2)
                io_ctrl_ab_ch1_q <= s_axi_wdata[7:0];
            if (wr_idx == 3'h3)
                io_ctrl_ab_ch2_q <= s_axi_wdata[7:0];
        end
    end

    // start, buffer, pwm2 and prescaler bits
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            ctrl_q <= tio_pkg::RST_TIMER_CTRL;
        else if (wr_go && wr_idx == 3'h4)
        begin
            if (s_axi_wstrb[0])
                ctrl_q[6:0] <= s_axi_wdata[6:0];
            if (s_axi_wstrb[1])
                ctrl_q[10:8] <= s_axi_wdata[10:8];
        end
    end

    assign start_w = ctrl_q[tio_pkg::CTL_START_LSB +: 3];
    assign pwm2_w = ctrl_q[tio_pkg::CTL_PWM2_LSB +: 3];
    assign psc_w = ctrl_q[tio_pkg::CTL_PSC_LSB +: 3];
    assign buf_b_w = ctrl_q[tio_pkg::CTL_BUFB_BIT];

    // ======================================================
    // read channel
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        unique case (rd_idx)
            3'h0: rdata_d[7:0] = io_ctrl_ab_ch0_q;
            3'h1: rdata_d[7:0] = io_ctrl_cd_ch0_q;
            3'h2: rdata_d[7:0] = io_ctrl_ab_ch1_q;
            3'h3: rdata_d[7:0] = io_ctrl_ab_ch2_q;
            3'h4: rdata_d[tio_pkg::CTL_W-1:0] = ctrl_q;
            3'h5: rdata_d[23:0] = {lvl_q, pin_oe, pin_o};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            arready_q <= 1'b0;
        else
            arready_q <= s_axi_arvalid & ~arready_q & ~rvalid_q;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rvalid_q <= 1'b0;
            rresp_q <= tio_pkg::RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end
        else if (rd_go)
        begin
            rvalid_q <= 1'b1;
            rresp_q <= (rd_idx == 3'h7) ? tio_pkg::RESP_SLVERR : tio_pkg::RESP_OKAY;
            rdata_q <= rdata_d;
        end
        else if (s_axi_rready)
            rvalid_q <= 1'b0;
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    // ======================================================
    // pin synchronisers and edge detect
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end
        else
        begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    assign agree_w = ~(sync2_q ^ sync3_q);
    // edges armed only once the third stage holds a real pin sample
    assign rise_w = {N{seeded_q}} & agree_w & sync3_q & ~lvl_q;
    assign fall_w = {N{seeded_q}} & agree_w & ~sync3_q & lvl_q;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            lvl_q <= '0;
            seeded_q <= 1'b0;
            warm_q <= 2'h0;
        end
        else
        begin
            lvl_q <= (agree_w & sync3_q) | (~agree_w & lvl_q);
            warm_q <= warm_q + {1'b0, ~&warm_q};
            seeded_q <= seeded_q | ((&warm_q) & (&agree_w));
        end
    end

    // ======================================================
    // register units: A0 B0 C0 D0 A1 B1 A2 B2
    assign codes_w = {io_ctrl_ab_ch2_q, io_ctrl_ab_ch1_q, io_ctrl_cd_ch0_q,
        io_ctrl_ab_ch0_q};

    generate
        for (genvar i = 0; i < N; i++)
        begin : g_unit
            localparam int CH = (i < 4) ? 0 : ((i < 6) ? 1 : 2);
            tio_unit_if u_if();
            assign u_if.code = codes_w[4*i +: 4];
            assign u_if.enable = !(i == 3 && buf_b_w);
            assign u_if.running = start_w[CH];
            assign u_if.pwm2 = pwm2_w[CH];
            assign u_if.clear = cnt_clear[CH];
            assign u_if.match = cmp_match[i];
            assign u_if.rise = rise_w[i];
            assign u_if.fall = fall_w[i];
            assign u_if.cascade_ok = (psc_w != tio_pkg::PSC_UNDIV);
            assign u_if.cascade_tick = cnt1_tick;
            tio_unit #(
                .CASCADE(i == 1 || i == 3)
            ) u_unit (
                .clk(clk),
                .rstn(rstn),
                .u(u_if.unit)
            );
            assign pin_o[i] = u_if.pin_o;
            assign pin_oe[i] = u_if.pin_oe;
            assign capture[i] = u_if.capture;
        end
    endgenerate

    // ======================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    assign oc0_w = start_w[0] && cmp_match[0] && !(pwm2_w[0] && cnt_clear[0])
        && !io_ctrl_ab_ch0_q[3];
    chk_read_back: assert property (
        rd_go && rd_idx == 3'h1 |=> s_axi_rdata[7:0] == $past(io_ctrl_cd_ch0_q))
        else $error("read data differs from code register");
    chk_init_stopped: assert property (
        $past(!start_w[0]) |-> pin_o[0] == $past(io_ctrl_ab_ch0_q[2]))
        else $error("initial level not applied while stopped");
    chk_drive_low: assert property (
        oc0_w && io_ctrl_ab_ch0_q[1:0] == 2'h1 |=> !pin_o[0])
        else $error("compare did not drive pin low");
    chk_drive_high: assert property (
        oc0_w && io_ctrl_ab_ch0_q[1:0] == 2'h2 |=> pin_o[0])
        else $error("compare did not drive pin high");
    chk_toggle_pin: assert property (
        oc0_w && io_ctrl_ab_ch0_q[1:0] == 2'h3 |=> pin_o[0] != $past(pin_o[0]))
        else $error("compare did not toggle pin");
    chk_oe_off: assert property (
        io_ctrl_ab_ch0_q[3] || io_ctrl_ab_ch0_q[1:0] == 2'h0 |=> !pin_oe[0])
        else $error("pin enabled with output disabled");
    chk_rise_cap: assert property (
        io_ctrl_ab_ch1_q[7:4] == 4'h8 |=> capture[5] == $past(rise_w[5]))
        else $error("rising edge capture wrong");
    chk_fall_cap: assert property (
        io_ctrl_ab_ch1_q[7:4] == 4'h9 |=> capture[5] == $past(fall_w[5]))
        else $error("falling edge capture wrong");
    chk_both_cap: assert property (
        io_ctrl_ab_ch1_q[7:5] == 3'h5 && (rise_w[5] || fall_w[5]) |=> capture[5])
        else $error("both edge capture missed");
    chk_cascade_tick: assert property (
        io_ctrl_cd_ch0_q[7:6] == 2'h3 && !buf_b_w && psc_w != 3'h0 && cnt1_tick |=> capture[3])
        else $error("cascaded capture missed");
    chk_cascade_gate: assert property (
        io_ctrl_ab_ch0_q[7:6] == 2'h3 && psc_w == 3'h0 |=> !capture[1])
        else $error("cascaded capture with undivided clock");
    chk_buffer_d: assert property (
        buf_b_w |=> !capture[3] && !pin_oe[3])
        else $error("register D active in buffer mode");
    chk_pwm2_clear: assert property (
        start_w[0] && pwm2_w[0] && cnt_clear[0] |=> pin_o[0] == $past(io_ctrl_ab_ch0_q[2]))
        else $error("pwm2 clear level wrong");
    chk_sync_delay: assert property (
        rise_w[0] |-> $past(pin_i[0], 3) && !$past(pin_i[0], 4))
        else $error("edge not three stages after pin");
    cov_rise_capture: cover property (io_ctrl_ab_ch1_q[7:4] == 4'h8 ##1 capture[5]);
    cov_toggle: cover property (pin_oe[0] ##1 $changed(pin_o[0]));
    cov_cascade: cover property (capture[3] && io_ctrl_cd_ch0_q[7:6] == 2'h3);
    cov_write_read: cover property (wr_go ##[1:8] rd_go);
endmodule : tio_top
`default_nettype wire

// File: tio_pkg.sv
// constants and types shared by the timer pin control block
package tio_pkg;

    // ======================================================
    // register byte offsets
    localparam logic [7:0] OFF_IO_CTRL_AB_CH0 = 8'h00;
    localparam logic [7:0] OFF_IO_CTRL_CD_CH0 = 8'h04;
    localparam logic [7:0] OFF_IO_CTRL_AB_CH1 = 8'h08;
    localparam logic [7:0] OFF_IO_CTRL_AB_CH2 = 8'h0C;
    localparam logic [7:0] OFF_TIMER_CTRL = 8'h10;
    localparam logic [7:0] OFF_PIN_STATUS = 8'h14;

    // ======================================================
    // function code fields
    localparam int FC_W = 4;
    localparam int FC_HI_LSB = 4;
    localparam int FC_LO_LSB = 0;
    localparam int CODE_CAP_BIT = 3;
    localparam int CODE_INIT_BIT = 2;
    localparam int CODE_CASC_BIT = 2;
    localparam int CODE_BOTH_BIT = 1;
    localparam int CODE_FALL_BIT = 0;

    // ======================================================
    // timer control register fields
    localparam int CTL_START_LSB = 0;
    localparam int CTL_BUFB_BIT = 3;
    localparam int CTL_PWM2_LSB = 4;
    localparam int CTL_PSC_LSB = 8;
    localparam int CTL_W = 11;
    localparam logic [2:0] PSC_UNDIV = 3'h0;

    // ======================================================
    // reset values
    localparam logic [7:0] RST_IO_CTRL = 8'h00;
    localparam logic [CTL_W-1:0] RST_TIMER_CTRL = 11'h000;

    // ======================================================
    // bus answers and counts
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int NUM_UNITS = 8;
    localparam int NUM_CH = 3;

    // output compare action from the low two code bits
    typedef enum logic [1:0] {OC_OFF, OC_LOW, OC_HIGH, OC_TOGGLE} tio_oc_act_t;

endpackage : tio_pkg

// File: tio_unit_if.sv
// signals between the register side and one general register unit
`timescale 1ns/10ps
`default_nettype none
interface tio_unit_if;
    logic [3:0] code;
    logic enable;
    logic running;
    logic pwm2;
    logic clear;
    logic match;
    logic rise;
    logic fall;
    logic cascade_ok;
    logic cascade_tick;
    logic pin_o;
    logic pin_oe;
    logic capture;

    modport ctl (output code, enable, running, pwm2, clear, match, rise, fall,
        cascade_ok, cascade_tick, input pin_o, pin_oe, capture);
    modport unit (input code, enable, running, pwm2, clear, match, rise, fall,
        cascade_ok, cascade_tick, output pin_o, pin_oe, capture);
endinterface : tio_unit_if
`default_nettype wire

// File: tio_unit.sv
// one general register: compare pin driver and capture trigger
`timescale 1ns/10ps
`default_nettype none
module tio_unit #(
    parameter bit CASCADE = 1'b0
) (
    input wire logic clk,
    input wire logic rstn,
    tio_unit_if.unit u
);
    logic lvl_q;
    logic oe_q;
    logic cap_q;
    logic cap_d;
    logic is_cmp;
    logic is_cap;
    tio_pkg::tio_oc_act_t act;

    assign is_cmp = u.enable & ~u.code[tio_pkg::CODE_CAP_BIT];
    assign is_cap = u.enable & u.code[tio_pkg::CODE_CAP_BIT];
    assign act = tio_pkg::tio_oc_act_t'(u.code[1:0]);

    // ======================================================
    // pin level
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            lvl_q <= 1'b0;
        else if (!u.running || (u.pwm2 && u.clear))
            lvl_q <= u.code[tio_pkg::CODE_INIT_BIT];
        else if (is_cmp && u.match)
        begin
            unique case (act)
                tio_pkg::OC_OFF: lvl_q <= lvl_q;
                tio_pkg::OC_LOW: lvl_q <= 1'b0;
                tio_pkg::OC_HIGH: lvl_q <= 1'b1;
                tio_pkg::OC_TOGGLE: lvl_q <= ~lvl_q;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            oe_q <= 1'b0;
        else
            oe_q <= is_cmp && (act != tio_pkg::OC_OFF);
    end

    // ======================================================
    // capture trigger
    always_comb
    begin
        if (!is_cap)
            cap_d = 1'b0;
        else if (CASCADE && u.code[tio_pkg::CODE_CASC_BIT])
            cap_d = u.cascade_ok & u.cascade_tick;
        else if (u.code[tio_pkg::CODE_BOTH_BIT])
            cap_d = u.rise | u.fall;
        else if (u.code[tio_pkg::CODE_FALL_BIT])
            cap_d = u.fall;
        else
            cap_d = u.rise;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            cap_q <= 1'b0;
        else
            cap_q <= cap_d;
    end

    assign u.pin_o = lvl_q;
    assign u.pin_oe = oe_q;
    assign u.capture = cap_q;
endmodule : tio_unit
`default_nettype wire

// File: tio_pin_model.sv
// external pin model: drives timer pins wherever the block does not
`timescale 1ns/10ps
`default_nettype none
module tio_pin_model (
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] drv_lvl,
    input wire logic [7:0] drv_en,
    output logic [7:0] pin_i
);
    // ==========================================
    // wire level: block drive first, then model, else pull-up
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            pin_i[i] = pin_oe[i] ? pin_o[i] : (drv_en[i] ? drv_lvl[i] : 1'b1);
        end
    end
endmodule : tio_pin_model
`default_nettype wire

// File: tb.sv
// self-checking bench for the timer pin control block
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk, rstn, awvalid, wvalid, bready, arvalid, rready, cnt1_tick;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr, cmp_match, pin_i, pin_o, pin_oe, capture, drv_lvl, drv_en, c;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [2:0] cnt_clear;
    int err_count, comparisons;
    logic [31:0] rd_q[$], mk_q[$];
    logic [1:0] rs_q[$], bs_q[$];
    logic [7:0] cap_q[$];
    logic [7:0] offs[4] = '{tio_pkg::OFF_IO_CTRL_AB_CH0, tio_pkg::OFF_IO_CTRL_CD_CH0,
        tio_pkg::OFF_IO_CTRL_AB_CH1, tio_pkg::OFF_IO_CTRL_AB_CH2};

    // ==========================================
    // clock, design and pin model
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    tio_top dut_u (.clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cmp_match(cmp_match), .cnt_clear(cnt_clear), .cnt1_tick(cnt1_tick),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .capture(capture));

    tio_pin_model pm_u (.pin_o(pin_o), .pin_oe(pin_oe), .drv_lvl(drv_lvl), .drv_en(drv_en),
        .pin_i(pin_i));

    // ==========================================
    // reporting and compares
    task automatic give_verdict;
        $display("counts: %0d compares, %0d mismatches", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
        input logic [31:0] mk);
        comparisons++;
        if (((got ^ exp) & mk) !== 32'h0)
        begin
            err_count++;
            $display("BAD t=%0t word got %h exp %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD t=%0t resp got %h exp %h", $time, got, exp);
        end
    endtask : chk_resp

    // ==========================================
    // bus master
    function automatic logic hs_sig(input int w);
        hs_sig = (w == 1) ? bvalid : ((w == 2) ? arready : rvalid);
    endfunction : hs_sig

    task automatic wait_hi(input int w);
        int n;
        n = 0;
        @(posedge clk);
        while (hs_sig(w) !== 1'b1)
        begin
            n++;
            if (n > 100)
            begin
                err_count++;
                $display("BAD t=%0t handshake timeout", $time);
                give_verdict();
            end
            @(posedge clk);
        end
    endtask : wait_hi

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
        logic aw_open;
        logic w_open;
        int n;
        aw_open = 1'b1;
        w_open = 1'b1;
        n = 0;
        bs_q.push_back(rsp);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw_open || w_open)
        begin
            @(posedge clk);
            if (aw_open && awready === 1'b1)
            begin
                awvalid <= 1'b0;
                aw_open = 1'b0;
            end
            if (w_open && wready === 1'b1)
            begin
                wvalid <= 1'b0;
                w_open = 1'b0;
            end
            n++;
            if (n > 100)
            begin
                err_count++;
                $display("BAD t=%0t write accept timeout", $time);
                give_verdict();
            end
        end
        wait_hi(1);
        bready <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mk,
        input logic [1:0] rsp);
        rd_q.push_back(exp);
        mk_q.push_back(mk);
        rs_q.push_back(rsp);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        wait_hi(2);
        arvalid <= 1'b0;
        wait_hi(3);
        rready <= 1'b0;
        @(posedge clk);
    endtask : rd

    // ==========================================
    // pin and counter stimulus
    task automatic pin_edge(input int u, input logic lvl, input logic [7:0] exp_cap);
        if (exp_cap != 8'h00)
            cap_q.push_back(exp_cap);
        drv_lvl[u] <= lvl;
        drv_en[u] <= !lvl;
        repeat (8) @(posedge clk);
    endtask : pin_edge

    task automatic pulse(input logic [7:0] m, input logic [2:0] clr, input logic t);
        cmp_match <= m;
        cnt_clear <= clr;
        cnt1_tick <= t;
        @(posedge clk);
        cmp_match <= 8'h00;
        cnt_clear <= 3'h0;
        cnt1_tick <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : pulse

    // ==========================================
    // result watcher: oldest note against each result
    always @(posedge clk)
    begin
        if (rvalid === 1'b1 && rready === 1'b1)
        begin
            chk_word(rdata, rd_q.pop_front(), mk_q.pop_front());
            chk_resp(rresp, rs_q.pop_front());
        end
        if (bvalid === 1'b1 && bready === 1'b1)
            chk_resp(bresp, bs_q.pop_front());
        if (capture !== 8'h00)
            chk_word({24'h0, capture},
                {24'h0, (cap_q.size() > 0) ? cap_q.pop_front() : 8'h00}, 32'hFF);
    end

    // ==========================================
    // main sequence
    initial
    begin
        {rstn, awvalid, wvalid, bready, arvalid, rready, cnt1_tick} = 7'h00;
        {awaddr, araddr, cmp_match, drv_lvl} = 32'h0;
        {wdata, wstrb, cnt_clear} = 39'h0;
        drv_en = 8'hFF;
        err_count = 0;
        comparisons = 0;
        void'($urandom(32'h30AF3AAC));
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 4; i++)
            rd(offs[i], 32'h0, 32'hFFFFFFFF, tio_pkg::RESP_OKAY);
        rd(8'h18, 32'h0, 32'hFFFFFFFF, tio_pkg::RESP_SLVERR);
        wr(8'h18, 32'hFF, tio_pkg::RESP_SLVERR);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            c = 8'($urandom()) & 8'h77;
            wr(offs[i % 4], {24'h0, c}, tio_pkg::RESP_OKAY);
            rd(offs[i % 4], {24'h0, c}, 32'hFFFFFFFF, tio_pkg::RESP_OKAY);
        end
        for (int i = 0; i < 4; i++)
            wr(offs[i], 32'h0, tio_pkg::RESP_OKAY);
        $display("test readback done");
        for (int k = 0; k < 8; k++)
        begin
            c = 8'(k);
            wr(tio_pkg::OFF_IO_CTRL_AB_CH0, {24'h0, c}, tio_pkg::RESP_OKAY);
            rd(tio_pkg::OFF_PIN_STATUS, {23'h0, c[1:0] != 2'h0, 7'h0, c[2]}, 32'h0101,
                tio_pkg::RESP_OKAY);
            wr(tio_pkg::OFF_TIMER_CTRL, 32'h1, tio_pkg::RESP_OKAY);
            pulse(8'h01, 3'h0, 1'b0);
            rd(tio_pkg::OFF_PIN_STATUS, {31'h0, (c[1:0] == 2'h0) ? c[2] : (c[1:0] == 2'h3) ?
                ~c[2] : c[1]}, 32'h01, tio_pkg::RESP_OKAY);
            wr(tio_pkg::OFF_TIMER_CTRL, 32'h0, tio_pkg::RESP_OKAY);
        end
        $display("test compare done");
        wr(tio_pkg::OFF_IO_CTRL_AB_CH0, 32'h5, tio_pkg::RESP_OKAY);
        wr(tio_pkg::OFF_TIMER_CTRL, 32'h11, tio_pkg::RESP_OKAY);
        pulse(8'h01, 3'h0, 1'b0);
        rd(tio_pkg::OFF_PIN_STATUS, 32'h0, 32'h01, tio_pkg::RESP_OKAY);
        pulse(8'h01, 3'h1, 1'b0);
        rd(tio_pkg::OFF_PIN_STATUS, 32'h1, 32'h01, tio_pkg::RESP_OKAY);
        wr(tio_pkg::OFF_TIMER_CTRL, 32'h0, tio_pkg::RESP_OKAY);
        wr(tio_pkg::OFF_IO_CTRL_AB_CH0, 32'h0, tio_pkg::RESP_OKAY);
        $display("test pwm2 done");
        for (int k = 0; k < 4; k++)
        begin
            wr(tio_pkg::OFF_IO_CTRL_AB_CH1, 32'(8 + k) << 4, tio_pkg::RESP_OKAY);
            pin_edge(5, 1'b1, (k != 1) ? 8'h20 : 8'h00);
            pin_edge(5, 1'b0, (k != 0) ? 8'h20 : 8'h00);
        end
        wr(tio_pkg::OFF_IO_CTRL_AB_CH1, 32'h0, tio_pkg::RESP_OKAY);
        $display("test edges done");
        wr(tio_pkg::OFF_IO_CTRL_CD_CH0, 32'h80, tio_pkg::RESP_OKAY);
        pin_edge(3, 1'b1, 8'h08);
        pin_edge(3, 1'b0, 8'h00);
        wr(tio_pkg::OFF_TIMER_CTRL, 32'h8, tio_pkg::RESP_OKAY);
        pin_edge(3, 1'b1, 8'h00);
        pin_edge(3, 1'b0, 8'h00);
        $display("test register d done");
        wr(tio_pkg::OFF_TIMER_CTRL, 32'h0, tio_pkg::RESP_OKAY);
        wr(tio_pkg::OFF_IO_CTRL_AB_CH0, 32'hC0, tio_pkg::RESP_OKAY);
        wr(tio_pkg::OFF_IO_CTRL_CD_CH0, 32'hC0, tio_pkg::RESP_OKAY);
        pulse(8'h00, 3'h0, 1'b1);
        wr(tio_pkg::OFF_TIMER_CTRL, 32'h100, tio_pkg::RESP_OKAY);
        cap_q.push_back(8'h0A);
        pulse(8'h00, 3'h0, 1'b1);
        repeat (8) @(posedge clk);
        chk_word(32'(cap_q.size()), 32'h0, 32'hFFFFFFFF);
        $display("test cascade done");
        give_verdict();
    end
endmodule : tb
`default_nettype wire
